/* File: rtl/fbp_pkg.sv */
package fbp_pkg;

    // register byte addresses on the wishbone slave
    localparam logic [7:0] FBP_ADR_DIR   = 8'h00;
    localparam logic [7:0] FBP_ADR_LATCH = 8'h04;
    localparam logic [7:0] FBP_ADR_VIEW  = 8'h08;
    localparam logic [7:0] FBP_ADR_FCTL  = 8'h0c;

    localparam int unsigned FBP_PINS   = 4;
    localparam int unsigned FBP_MODE_W = 3;
    localparam int unsigned FBP_SYNC_W = 7;

    // reset values
    localparam logic [3:0] FBP_DIR_RST   = 4'h0;
    localparam logic [3:0] FBP_LATCH_RST = 4'h0;
    localparam logic [7:0] FBP_FCTL_RST  = 8'hf0;

    // value returned for bits that have no defined read value
    localparam logic [31:0] FBP_UNDEF_RD = 32'h0000_0000;

    // function control field positions
    localparam int unsigned FBP_FC_SEL_LO = 4;
    localparam int unsigned FBP_FC_EXTERNAL_EXPANSION_ENABLE   = 3;
    localparam int unsigned FBP_FC_OEE    = 1;
    localparam int unsigned FBP_FC_OES    = 0;

    // operating modes
    localparam logic [2:0] FBP_MODE_1 = 3'h1;
    localparam logic [2:0] FBP_MODE_2 = 3'h2;
    localparam logic [2:0] FBP_MODE_4 = 3'h4;
    localparam logic [2:0] FBP_MODE_5 = 3'h5;
    localparam logic [2:0] FBP_MODE_6 = 3'h6;
    localparam logic [2:0] FBP_MODE_7 = 3'h7;

    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe_n;
    } fbp_pin_drive_t;

    typedef struct packed {
        logic [3:0]     dir;
        logic [3:0]     latch;
        logic [7:0]     fctl;
        logic           ack;
        logic [31:0]    rdata;
        fbp_pin_drive_t drive;
    } fbp_state_t;

endpackage : fbp_pkg

/* File: rtl/fbp_sync2.sv */
`timescale 1ns/1ps
`default_nettype none
module fbp_sync2
    import fbp_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic [FBP_SYNC_W-1:0] async_in,
    output logic      [FBP_SYNC_W-1:0] sync_out
);
    logic [FBP_SYNC_W-1:0] stage1_ff;
    logic [FBP_SYNC_W-1:0] stage2_ff;

    // first stage feeds only the second one
    always_ff @(posedge clk) begin
        if (rst) begin
            stage1_ff <= '0;
            stage2_ff <= '0;
        end else begin
            stage1_ff <= async_in;
            stage2_ff <= stage1_ff;
        end
    end

    assign sync_out = stage2_ff;
endmodule : fbp_sync2
`default_nettype wire

/* File: rtl/fbp_port.sv */
`timescale 1ns/1ps
`default_nettype none
module fbp_port
    import fbp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [2:0]  mode_pins,
    input  wire logic [3:0]  select_n_in,
    input  wire logic        read_strobe_n_in,
    input  wire logic [3:0]  pin_in,
    output logic      [3:0]  pin_out,
    output logic      [3:0]  pin_oe_n
);

    ////////////////////////////////////////////////////////////////////////////
    fbp_state_t st_ff;
    fbp_state_t nxt_st;

    logic [FBP_SYNC_W-1:0] sync_bits;
    logic [3:0]            pin_lvl;
    logic [2:0]            mode;

    // mode straps may change asynchronously, so they ride the same synchroniser
    fbp_sync2 u_sync (
        .clk      (clk),
        .rst      (rst),
        .async_in ({mode_pins, pin_in}),
        .sync_out (sync_bits)
    );

    assign pin_lvl = sync_bits[3:0];
    assign mode    = sync_bits[6:4];

    ////////////////////////////////////////////////////////////////////////////
    logic       exp_active;
    logic       strobe_sel;
    logic [3:0] sel_en;
    logic [3:0] view;
    logic       req;
    logic       wr_lane0;

    always_comb begin
        unique case (mode)
            FBP_MODE_1, FBP_MODE_2, FBP_MODE_4,
            FBP_MODE_5, FBP_MODE_6: exp_active = 1'b1;
            FBP_MODE_7:             exp_active = st_ff.fctl[FBP_FC_EXTERNAL_EXPANSION_ENABLE];
            default:                exp_active = 1'b0;
        endcase
    end

    assign strobe_sel = exp_active & st_ff.fctl[FBP_FC_OEE] & st_ff.fctl[FBP_FC_OES];
    assign sel_en     = {4{exp_active}} & st_ff.fctl[FBP_FC_SEL_LO +: 4];

    // live view, no stored copy; input pins reach it through the two-flop synchroniser, two clocks late
    assign view = (st_ff.dir & st_ff.latch) | (~st_ff.dir & pin_lvl);

    assign req      = wb_cyc_i & wb_stb_i & ~st_ff.ack;
    assign wr_lane0 = req & wb_we_i & wb_sel_i[0];

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_st     = st_ff;
        nxt_st.ack = req;

        if (wr_lane0) begin
            unique case (wb_adr_i)
                FBP_ADR_DIR:   nxt_st.dir   = wb_dat_i[3:0];
                FBP_ADR_LATCH: nxt_st.latch = wb_dat_i[3:0];
                FBP_ADR_FCTL:  nxt_st.fctl  = wb_dat_i[7:0];
                default:       nxt_st.fctl  = st_ff.fctl;
            endcase
        end

        if (req && !wb_we_i) begin
            unique case (wb_adr_i)
                FBP_ADR_DIR:   nxt_st.rdata = FBP_UNDEF_RD;
                FBP_ADR_LATCH: nxt_st.rdata = {28'h0000000, st_ff.latch};
                FBP_ADR_VIEW:  nxt_st.rdata = {FBP_UNDEF_RD[31:4], view};
                FBP_ADR_FCTL:  nxt_st.rdata = {24'h000000, st_ff.fctl};
                default:       nxt_st.rdata = FBP_UNDEF_RD;
            endcase
        end else if (req) begin
            nxt_st.rdata = FBP_UNDEF_RD;
        end

        // pin drive; strobe outranks select, select outranks latch
        for (int i = 0; i < FBP_PINS; i++) begin
            if (i == 3 && strobe_sel) begin
                nxt_st.drive.out[i]  = read_strobe_n_in;
                nxt_st.drive.oe_n[i] = 1'b0;
            end else if (sel_en[i] && st_ff.dir[i]) begin
                nxt_st.drive.out[i]  = select_n_in[i];
                nxt_st.drive.oe_n[i] = 1'b0;
            end else begin
                nxt_st.drive.out[i]  = st_ff.latch[i];
                nxt_st.drive.oe_n[i] = ~st_ff.dir[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff.dir        <= FBP_DIR_RST;
            st_ff.latch      <= FBP_LATCH_RST;
            st_ff.fctl       <= FBP_FCTL_RST;
            st_ff.ack        <= 1'b0;
            st_ff.rdata      <= FBP_UNDEF_RD;
            st_ff.drive.out  <= 4'h0;
            st_ff.drive.oe_n <= 4'hf;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign wb_ack_o = st_ff.ack;
    assign wb_dat_o = st_ff.rdata;
    assign pin_out  = st_ff.drive.out;
    assign pin_oe_n = st_ff.drive.oe_n;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_write(logic [7:0] a);
        wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !wb_ack_o && wb_adr_i == a;
    endsequence

    sequence s_read_ack(logic [7:0] a);
        wb_ack_o && !wb_we_i && wb_adr_i == a;
    endsequence

    a_dir_write: assert property (s_write(FBP_ADR_DIR) |=> st_ff.dir == $past(wb_dat_i[3:0]))
        else $error("direction write not stored");
    a_dir_read_hidden: assert property (s_read_ack(FBP_ADR_DIR) |-> wb_dat_o == FBP_UNDEF_RD)
        else $error("direction read leaked state");
    a_view_upper_fixed: assert property (s_read_ack(FBP_ADR_VIEW) |-> wb_dat_o[31:4] == 28'h0)
        else $error("view upper bits not fixed");
    a_strobe_on_pin3: assert property (strobe_sel |=> !pin_oe_n[3] && pin_out[3] == $past(read_strobe_n_in))
        else $error("pin 3 not driving strobe");
    a_select7_drive: assert property (!strobe_sel && sel_en[3] && st_ff.dir[3]
        |=> !pin_oe_n[3] && pin_out[3] == $past(select_n_in[3]))
        else $error("pin 3 not driving select7");
    a_pin3_gpio: assert property (!strobe_sel && !sel_en[3]
        |=> pin_oe_n[3] == !$past(st_ff.dir[3]) && pin_out[3] == $past(st_ff.latch[3]))
        else $error("pin 3 gpio wrong");
    a_low_select_drive: assert property (sel_en[0] && st_ff.dir[0] ##1 sel_en[0] && st_ff.dir[0]
        |-> pin_out[0] == $past(select_n_in[0]) && !pin_oe_n[0])
        else $error("pin 0 select not driven");
    a_low_gpio: assert property (!sel_en[2] |=> pin_oe_n[2] == !$past(st_ff.dir[2]))
        else $error("pin 2 direction wrong");
    a_mode7_plain: assert property (mode == FBP_MODE_7 && !st_ff.fctl[FBP_FC_EXTERNAL_EXPANSION_ENABLE]
        |=> pin_out == $past(st_ff.latch) && pin_oe_n == ~$past(st_ff.dir))
        else $error("mode 7 pins not plain");
    a_latch_upper_zero: assert property (s_read_ack(FBP_ADR_LATCH) |-> wb_dat_o[31:4] == 28'h0)
        else $error("latch upper bits nonzero");
    a_view_value: assert property (s_read_ack(FBP_ADR_VIEW) |-> wb_dat_o[3:0] == $past(view))
        else $error("view read wrong");
    a_view_ro: assert property (s_write(FBP_ADR_VIEW) |=> $stable(st_ff.dir) && $stable(st_ff.latch))
        else $error("view write changed state");
    a_reset_clear: assert property ($fell(rst) |-> st_ff.dir == 4'h0 && st_ff.latch == 4'h0)
        else $error("reset did not clear");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");

endmodule : fbp_port
`default_nettype wire

/* File: dv/fbp_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fbp_pin_model (
    input  wire logic [3:0] pin_out,
    input  wire logic [3:0] pin_oe_n,
    input  wire logic [3:0] ext_lvl,
    output logic      [3:0] pin_lvl
);
    // far side drives whatever pin the device has let go; a driven pin shows the device value
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pin_lvl[i] = pin_oe_n[i] ? ext_lvl[i] : pin_out[i];
        end
    end
endmodule : fbp_pin_model
`default_nettype wire

/* File: dv/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
    import fbp_pkg::*;
;
    logic        clk, rst, cyc, stb, we, ack, rsn;
    logic [3:0]  sel, seln, ext, lvl, pin_out, pin_oe_n;
    logic [7:0]  adr, fctl, dir, latch;
    logic [31:0] dat_w, dat_r, rd;
    logic [2:0]  mode;
    // mode 3 is decoded as plain i/o, so it is swept too
    logic [2:0]  modes [7] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
    logic [7:0]  fcs [4] = '{8'hf8, 8'hfa, 8'hfb, 8'h58};
    int          num_errors, num_checks;

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    fbp_port i_dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
        .mode_pins(mode), .select_n_in(seln), .read_strobe_n_in(rsn), .pin_in(lvl),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n));

    fbp_pin_model i_far (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_lvl(ext), .pin_lvl(lvl));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        if (num_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : final_report

    task automatic cmp(input string name, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, e, g);
        end
    endtask : cmp

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= w;
        adr   <= a;
        dat_w <= d;
        n = 0;
        // ack is sampled at the edge; the request stands until then
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) begin
            num_errors++;
            final_report();
        end
        rd = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : bus

    task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        cmp(name, e, rd);
    endtask : rdc

    task automatic cfg(input logic [7:0] f, input logic [7:0] d, input logic [7:0] l);
        fctl  = f;
        dir   = d;
        latch = l;
        bus(1'b1, FBP_ADR_FCTL, {24'h0, f});
        bus(1'b1, FBP_ADR_DIR, {24'h0, d});
        bus(1'b1, FBP_ADR_LATCH, {24'h0, l});
    endtask : cfg

    // reference pin function, returns {out, oe_n}
    function automatic logic [7:0] exp_pins();
        logic [3:0] o, oe_n;
        logic       x;
        x = (mode inside {3'h1, 3'h2, 3'h4, 3'h5, 3'h6}) || (mode == 3'h7 && fctl[3]);
        o = latch[3:0];
        oe_n = ~dir[3:0];
        for (int i = 0; i < 4; i++) if (x && fctl[4+i] && dir[i]) o[i] = seln[i];
        if (x && fctl[1] && fctl[0]) begin
            o[3] = rsn;
            oe_n[3] = 1'b0;
        end
        return {o, oe_n};
    endfunction : exp_pins

    task automatic chk;
        logic [7:0] e;
        logic [3:0] p;
        repeat (4) @(posedge clk);
        e = exp_pins();
        p = (e[7:4] & ~e[3:0]) | (ext & e[3:0]);
        cmp("pin_oe_n", {28'h0, e[3:0]}, {28'h0, pin_oe_n});
        cmp("pin_out", {28'h0, e[7:4] & ~e[3:0]}, {28'h0, pin_out & ~pin_oe_n});
        rdc("pin_level_view", FBP_ADR_VIEW, {28'h0, (dir[3:0] & latch[3:0]) | (~dir[3:0] & p)});
    endtask : chk

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; sel = 4'h1; adr = 8'h0; dat_w = 32'h0;
        mode = 3'h7; seln = 4'h5; rsn = 1'b1; ext = 4'ha; fctl = FBP_FCTL_RST;
        dir = 8'h0; latch = 8'h0; num_errors = 0; num_checks = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        chk();
        ext <= 4'h6;
        chk();
        rdc("pin_output_latch", FBP_ADR_LATCH, 32'h0);
        rdc("pin_direction_control", FBP_ADR_DIR, FBP_UNDEF_RD);
        rdc("unmapped", 8'h10, 32'h0);
        bus(1'b1, FBP_ADR_LATCH, 32'hff);
        latch = 8'h0f;
        rdc("pin_output_latch", FBP_ADR_LATCH, 32'hf);
        // a write without byte lane 0 must leave the latch alone
        sel <= 4'he;
        bus(1'b1, FBP_ADR_LATCH, 32'h0);
        sel <= 4'h1;
        rdc("pin_output_latch", FBP_ADR_LATCH, 32'hf);
        bus(1'b1, FBP_ADR_VIEW, 32'h5);
        chk();
        cfg(8'hf3, 8'hff, 8'h05);
        chk();
        cfg(8'h00, 8'h03, 8'h05);
        chk();
        // every expansion mode against each select/strobe mix, outputs and inputs
        foreach (modes[k]) begin
            mode <= modes[k];
            foreach (fcs[j]) begin
                cfg(fcs[j], 8'hff, 8'h0a);
                chk();
                cfg(fcs[j], 8'h00, 8'h0a);
                chk();
            end
        end
        final_report();
    end
endmodule : tb
`default_nettype wire
